// ==== uart_irda_chk.sv ====
`default_nettype none

// ----------------------------------------
// Port checker for the serial block
// ----------------------------------------
module uart_irda_chk (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus.
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  // Pins.
  input wire logic        txd_pin,
  input wire logic        rx_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       ir_on, tx_on, rx_on, b1;  // Enable and divisor shadows.
  logic [7:0] lowcnt;                   // Low run length of the pin.
  logic       wr;                       // A register write is taken.
  assign wr = awvalid && awready && wvalid && wready;
  // Shadow control writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ir_on, tx_on, rx_on, b1} <= 4'h1;
      lowcnt <= 8'hff;
    end else begin
      if (wr && awaddr == 8'h0c) ir_on <= wdata[4];
      if (wr && awaddr == 8'h08) {tx_on, rx_on} <= wdata[1:0];
      if (wr && awaddr == 8'h14) b1 <= (wdata[15:0] < 16'h2);
      lowcnt <= txd_pin ? 8'h0 : lowcnt + {7'h0, lowcnt != 8'hff};
    end
  end
  AST_IR_PULSE: assert property (ir_on && b1 && $rose(txd_pin) |-> txd_pin[*3] ##1 !txd_pin)
    else $error("bad ir pulse");
  AST_IR_GAP: assert property (ir_on && b1 && $past(ir_on, 3) && $rose(txd_pin) |-> lowcnt >= 8'd13)
    else $error("ir gap short");
  AST_IR_IDLE: assert property (ir_on && $past(ir_on, 3) && !tx_on |-> !txd_pin)
    else $error("ir not idle low");
  AST_UART_IDLE: assert property (!ir_on && !$past(ir_on, 3) && !tx_on |-> txd_pin)
    else $error("tx not idle high");
  AST_IRQ_RX: assert property ($rose(rx_irq) |-> rx_on)
    else $error("irq without rx");
  AST_RD_LAT: assert property (arvalid && arready |=> rvalid)
    else $error("r late");
  AST_WR_LAT: assert property (wr |-> ##[1:2] bvalid)
    else $error("b late");
  AST_B_DROP: assert property (bvalid && bready |=> !bvalid)
    else $error("bvalid stuck");
  AST_UNMAPPED: assert property (arvalid && arready && araddr > 8'h14 |=> rresp == uart_irda_pkg::RESP_ERR && rdata == 32'h0)
    else $error("unmapped read ok");
  cover property ($rose(rx_irq));
  cover property (ir_on && $rose(txd_pin));
  cover property (arvalid && arready && araddr > 8'h14);
endmodule : uart_irda_chk

bind uart_irda_rx uart_irda_chk chk (.*);

`default_nettype wire

// ==== uart_irda_peer.sv ====
`default_nettype none

// ----------------------------------------
// Far-side peer sending plain or infrared frames
// ----------------------------------------
module uart_irda_peer (
  // Clock and line.
  input  wire logic aclk,
  output var logic  rxd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd_pin = 1'b1;  // A plain line idles high.
  // Idle level: low infrared, high plain.
  task automatic idle(input logic ir);
    @(posedge aclk);
    rxd_pin <= !ir;
  endtask : idle
  // One bit of bt cycles; an infrared zero is a pulse over ticks 7 to 9.
  task automatic bit_out(input logic b, input logic ir, input int bt);
    for (int i = 0; i < bt; i++) begin
      @(posedge aclk);
      rxd_pin <= ir ? (!b && i >= 7 * bt / 16 && i < 10 * bt / 16) : b;
    end
  endtask : bit_out
  // Start bit, n data bits least first, stop bit, then idle.
  task automatic send(input logic [8:0] d, input int n, input logic s, input logic ir,
                      input int bt);
    bit_out(1'b0, ir, bt);
    for (int i = 0; i < n; i++) bit_out(d[i], ir, bt);
    bit_out(s, ir, bt);
    idle(ir);
  endtask : send
endmodule : uart_irda_peer

`default_nettype wire

// ==== uart_irda_pkg.sv ====
// Function
// - Interrupt on data, break, overrun, framing error.
// - Data interrupt masked apart from error sources.
// - Data interrupt only after byte is held.
// - Multidrop interrupts follow scheme and last address.
// - Overrun keeps the held byte unchanged.
// - Overrun and break hidden until byte read.
// - After that read, overrun and available show.
// - Break flag tells if overrun was break.
// - Second data read clears the error bits.
// - Data register reloads only on complete word.
// - Transmit data write clears holding empty flag.
// - Infrared link never transmits and receives together.
// - Bit rate is clock over sixteen times divisor.
// - A one bit keeps output low sixteen clocks.
// - A zero bit: 7 low, 3 high, 6 low.
// - Endec enabled puts encoded output on transmit pin.
// - Pulse search window ends eight clocks past expected.
// - Each falling edge restarts the endec counter.
`default_nettype none

package uart_irda_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h00;  // Receive read, transmit write.
  localparam logic [7:0] ADDR_STAT = 8'h04;  // Status, read only.
  localparam logic [7:0] ADDR_CTL0 = 8'h08;  // Enables and parity.
  localparam logic [7:0] ADDR_CTL1 = 8'h0c;  // Multidrop, masks, infrared.
  localparam logic [7:0] ADDR_NODE = 8'h10;  // Own node address.
  localparam logic [7:0] ADDR_BAUD = 8'h14;  // Baud divisor.

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ST_AVAIL = 0;  // Byte held.
  localparam int ST_OVR   = 1;  // Overrun.
  localparam int ST_FRM   = 2;  // Framing error.
  localparam int ST_PAR   = 3;  // Parity error.
  localparam int ST_BRK   = 4;  // Break detected.
  localparam int ST_THE   = 5;  // Transmit holding empty.
  localparam int ST_TXB   = 6;  // Transmitter busy.
  localparam int ST_ADR   = 7;  // Held byte was an address.
  localparam int C0_RXEN  = 0;  // Receive enable.
  localparam int C0_TXEN  = 1;  // Transmit enable.
  localparam int C0_PEN   = 2;  // Parity enable.
  localparam int C0_PODD  = 3;  // Odd parity.
  localparam int C1_MDEN  = 0;  // Multidrop enable.
  localparam int C1_SCH   = 1;  // Address scheme, two bits.
  localparam int C1_DIE   = 3;  // Received data interrupt enable.
  localparam int C1_INFRARED_ENABLE  = 4;  // Infrared enable.
  localparam int C1_TXADR = 5;  // Ninth bit sent in multidrop.

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [15:0] BAUD_RST  = 16'h0001;  // Divisor after reset.
  localparam logic [3:0]  TICK_LAST = 4'hf;      // Last of 16 ticks per bit.
  localparam logic [3:0]  TICK_MID  = 4'h7;      // Start bit checked here.
  localparam logic [3:0]  IR_HI_LO  = 4'h7;      // First high tick of pulse.
  localparam logic [3:0]  IR_HI_HI  = 4'h9;      // Last high tick of pulse.
  localparam logic [4:0]  DEC_BIT   = 5'h10;     // Next pulse expected here.
  localparam logic [4:0]  DEC_WIN   = 5'h18;     // Window ends 8 ticks later.
  localparam logic [1:0]  RESP_OK   = 2'h0;      // Bus answer, accepted.
  localparam logic [1:0]  RESP_ERR  = 2'h2;      // Bus answer, unmapped.

  // Receiver sequence.
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;

endpackage : uart_irda_pkg

`default_nettype wire

// ==== uart_irda_rx.sv ====
`default_nettype none

module uart_irda_rx (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // Write data channel.
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response channel.
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read address channel.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // Read data channel.
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Serial pins and interrupt.
  input  wire logic        rxd_pin,
  output logic             txd_pin,
  output logic             rx_irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // All flip-flops of the block in one record.
  typedef struct packed {
    logic                   rx_s1;        // First synchroniser stage.
    logic                   rx_s2;        // Second synchroniser stage.
    logic                   rx_prev;      // Delayed copy for edge finding.
    logic [15:0]            baud_cnt;     // Divider count.
    logic                   tick;         // 16x baud enable pulse.
    logic [3:0]             ctl0;         // Enables and parity.
    logic [5:0]             ctl1;         // Multidrop, mask, infrared.
    logic [7:0]             node;         // Own address.
    logic [15:0]            baud_div;     // Divisor.
    uart_irda_pkg::rx_state_t rx_st;      // Receiver state.
    logic [3:0]             rx_tck;       // Tick within bit.
    logic [3:0]             rx_bitn;      // Bits taken so far.
    logic [8:0]             rx_shift;     // Incoming bits.
    logic [7:0]             rx_data;      // Held byte.
    logic                   rx_avail;     // Held byte valid.
    logic                   ovr_pend;     // Overrun not yet shown.
    logic                   brk_pend;     // Break behind hidden overrun.
    logic                   overrun;      // Overrun shown.
    logic                   break_detected; // Break shown.
    logic                   framing;      // Framing error.
    logic                   parity_err;   // Parity error.
    logic                   rx_is_addr;   // Held byte is an address.
    logic                   addr_match;   // Last address was ours.
    logic [7:0]             tx_hold;      // Transmit holding byte.
    logic                   tx_holding_empty; // Holding byte free.
    logic                   tx_busy;      // Shifter running.
    logic [10:0]            tx_shift;     // Outgoing frame.
    logic [3:0]             tx_left;      // Bits still to send.
    logic [3:0]             tx_tck;       // Tick within bit.
    logic                   dec_active;   // Decoder following pulses.
    logic [4:0]             dec_cnt;      // Endec clock counter.
    logic                   dec_out;      // Decoded serial level.
    logic                   aw_got;       // Write address captured.
    logic                   w_got;        // Write data captured.
    logic [7:0]             aw_addr;      // Captured write address.
    logic [31:0]            w_data;       // Captured write data.
    logic [3:0]             w_strb;       // Captured strobes.
    logic                   awready;      // Address ready.
    logic                   wready;       // Data ready.
    logic                   bvalid;       // Response valid.
    logic [1:0]             bresp;        // Response code.
    logic                   arready;      // Read address ready.
    logic                   rvalid;       // Read data valid.
    logic [31:0]            rdata;        // Read data.
    logic [1:0]             rresp;        // Read response.
    logic                   txd_pin;      // Transmit pin level.
    logic                   rx_irq;       // Interrupt level.
  } state_t;

  state_t s;       // Current state.
  state_t next_s;  // Next state.

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;
  assign txd_pin = s.txd_pin;
  assign rx_irq  = s.rx_irq;

  // ----------------------------------------
  // Next state logic
  // ----------------------------------------
  // Updates run in order, so later steps see earlier ones;
  // a completed character wins over a clearing read.
  always_comb begin
    state_t n;
    logic   uart_en;
    logic   ir_en;
    logic   mp;
    logic   extra;
    logic   rx_bit;
    logic   fall;
    logic   stop_bit;
    logic   frm;
    logic   brk;
    logic   perr;
    logic   irq_ok;
    logic   ir_pulse;
    logic   rd;
    logic   wr;
    logic [7:0] rx_byte;
    logic [31:0] rmux;
    n        = s;
    uart_en  = s.ctl0[uart_irda_pkg::C0_RXEN] | s.ctl0[uart_irda_pkg::C0_TXEN];
    ir_en    = s.ctl1[uart_irda_pkg::C1_INFRARED_ENABLE];
    mp       = s.ctl1[uart_irda_pkg::C1_MDEN];
    extra    = mp | s.ctl0[uart_irda_pkg::C0_PEN];
    fall     = s.rx_prev & ~s.rx_s2;
    stop_bit = 1'b0;
    frm      = 1'b0;
    brk      = 1'b0;
    perr     = 1'b0;
    irq_ok   = 1'b1;
    ir_pulse = 1'b0;
    rd       = 1'b0;
    wr       = 1'b0;
    rx_byte  = 8'h00;
    rmux     = 32'h0000_0000;

    // Pin synchroniser; only the second stage feeds logic.
    n.rx_s1   = rxd_pin;
    n.rx_s2   = s.rx_s1;
    n.rx_prev = s.rx_s2;

    // Baud divider: one tick per divisor cycles, 16 ticks per bit.
    n.tick = 1'b0;
    if (uart_en) begin
      if ({1'b0, s.baud_cnt} + 17'h00001 >= {1'b0, s.baud_div}) begin
        n.tick     = 1'b1;
        n.baud_cnt = 16'h0000;
      end else begin
        n.baud_cnt = s.baud_cnt + 16'h0001;
      end
    end else begin
      n.baud_cnt = 16'h0000;
    end

    // Infrared decoder, held off while transmitting.
    if (!(ir_en && uart_en) || s.tx_busy) begin
      n.dec_active = 1'b0;
      n.dec_cnt    = 5'h00;
      n.dec_out    = 1'b1;
    end else if (fall) begin
      // Each pulse restarts the counter and marks a zero bit.
      n.dec_active = 1'b1;
      n.dec_cnt    = 5'h00;
      n.dec_out    = 1'b0;
    end else if (s.tick && s.dec_active) begin
      n.dec_cnt = s.dec_cnt + 5'h01;
      if (n.dec_cnt >= uart_irda_pkg::DEC_BIT) begin
        n.dec_out = 1'b1;
      end
      if (n.dec_cnt >= uart_irda_pkg::DEC_WIN) begin
        n.dec_active = 1'b0;
      end
    end

    // Receive line comes from the decoder in infrared mode.
    rx_bit = ir_en ? s.dec_out : s.rx_s2;

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (s.arready && arvalid) begin
      rd      = 1'b1;
      n.rresp = uart_irda_pkg::RESP_OK;
      unique case (araddr)
        uart_irda_pkg::ADDR_DATA: rmux = {24'h000000, s.rx_data};
        uart_irda_pkg::ADDR_STAT: rmux = {24'h000000, s.rx_is_addr, s.tx_busy,
                                          s.tx_holding_empty, s.break_detected,
                                          s.parity_err, s.framing, s.overrun,
                                          s.rx_avail};
        uart_irda_pkg::ADDR_CTL0: rmux = {28'h0000000, s.ctl0};
        uart_irda_pkg::ADDR_CTL1: rmux = {26'h0000000, s.ctl1};
        uart_irda_pkg::ADDR_NODE: rmux = {24'h000000, s.node};
        uart_irda_pkg::ADDR_BAUD: rmux = {16'h0000, s.baud_div};
        default:                  n.rresp = uart_irda_pkg::RESP_ERR;
      endcase
      n.rdata  = rmux;
      n.rvalid = 1'b1;
    end

    // Data reads walk the overrun sequence.
    if (rd && araddr == uart_irda_pkg::ADDR_DATA) begin
      if (s.overrun) begin
        // Second read after the overrun shows: all errors clear.
        n.overrun        = 1'b0;
        n.break_detected = 1'b0;
        n.framing        = 1'b0;
        n.parity_err     = 1'b0;
        n.rx_avail       = 1'b0;
      end else if (s.ovr_pend) begin
        // Valid byte taken; now reveal overrun, keep available set.
        n.overrun        = 1'b1;
        n.break_detected = s.brk_pend;
        n.rx_avail       = 1'b1;
        n.ovr_pend       = 1'b0;
        n.brk_pend       = 1'b0;
      end else begin
        n.rx_avail       = 1'b0;
        n.break_detected = 1'b0;
        n.framing        = 1'b0;
        n.parity_err     = 1'b0;
      end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    if (!s.ctl0[uart_irda_pkg::C0_RXEN]) begin
      n.rx_st = uart_irda_pkg::RX_IDLE;
    end else if (s.tick) begin
      n.rx_tck = s.rx_tck + 4'h1;
      unique case (s.rx_st)
        uart_irda_pkg::RX_IDLE: begin
          // Resynchronise only on a start bit.
          n.rx_tck = 4'h0;
          if (!rx_bit) begin
            n.rx_st = uart_irda_pkg::RX_START;
          end
        end
        uart_irda_pkg::RX_START: begin
          if (s.rx_tck == uart_irda_pkg::TICK_MID) begin
            n.rx_tck  = 4'h0;
            n.rx_bitn = 4'h0;
            n.rx_st   = rx_bit ? uart_irda_pkg::RX_IDLE : uart_irda_pkg::RX_BITS;
          end
        end
        uart_irda_pkg::RX_BITS: begin
          if (s.rx_tck == uart_irda_pkg::TICK_LAST) begin
            n.rx_shift = {rx_bit, s.rx_shift[8:1]};
            n.rx_bitn  = s.rx_bitn + 4'h1;
            if (s.rx_bitn == (extra ? 4'h8 : 4'h7)) begin
              n.rx_st = uart_irda_pkg::RX_STOP;
            end
          end
        end
        uart_irda_pkg::RX_STOP: begin
          if (s.rx_tck == uart_irda_pkg::TICK_LAST) begin
            stop_bit = 1'b1;
            n.rx_st  = uart_irda_pkg::RX_IDLE;
          end
        end
      endcase
    end

    // Word done: load it, or drop it as an overrun.
    if (stop_bit) begin
      rx_byte = extra ? s.rx_shift[7:0] : s.rx_shift[8:1];
      frm     = ~rx_bit;
      brk     = frm && rx_byte == 8'h00 && !(extra && s.rx_shift[8]);
      perr    = s.ctl0[uart_irda_pkg::C0_PEN] && !mp &&
                ((^{rx_byte, s.rx_shift[8]}) != s.ctl0[uart_irda_pkg::C0_PODD]);
      if (mp && s.rx_shift[8]) begin
        n.addr_match = (rx_byte == s.node);
      end
      if (n.rx_avail) begin
        // Held byte is kept; the new one is dropped.
        n.ovr_pend = 1'b1;
        n.brk_pend = s.brk_pend | brk;
      end else begin
        n.rx_data        = rx_byte;
        n.rx_avail       = 1'b1;
        n.framing        = frm;
        n.break_detected = brk;
        n.parity_err     = perr;
        n.rx_is_addr     = mp & s.rx_shift[8];
      end
    end

    // ----------------------------------------
    // Transmitter and encoder
    // ----------------------------------------
    if (!s.ctl0[uart_irda_pkg::C0_TXEN]) begin
      n.tx_busy = 1'b0;
    end else if (!s.tx_busy) begin
      // Half duplex: no start mid-frame in infrared mode.
      if (!s.tx_holding_empty && !(ir_en && s.rx_st != uart_irda_pkg::RX_IDLE)) begin
        n.tx_shift = {1'b1,
                      mp ? s.ctl1[uart_irda_pkg::C1_TXADR]
                         : (^s.tx_hold) ^ s.ctl0[uart_irda_pkg::C0_PODD],
                      s.tx_hold, 1'b0};
        if (!extra) begin
          n.tx_shift[9] = 1'b1;
        end
        n.tx_left          = extra ? 4'hb : 4'ha;
        n.tx_tck           = 4'h0;
        n.tx_busy          = 1'b1;
        n.tx_holding_empty = 1'b1;
      end
    end else if (s.tick) begin
      n.tx_tck = s.tx_tck + 4'h1;
      if (s.tx_tck == uart_irda_pkg::TICK_LAST) begin
        n.tx_shift = {1'b1, s.tx_shift[10:1]};
        n.tx_left  = s.tx_left - 4'h1;
        if (s.tx_left == 4'h1) begin
          n.tx_busy = 1'b0;
        end
      end
    end

    // A zero bit gives a 3-tick pulse after 7 low ticks; a one stays low.
    ir_pulse = s.tx_busy && !s.tx_shift[0] &&
               s.tx_tck >= uart_irda_pkg::IR_HI_LO &&
               s.tx_tck <= uart_irda_pkg::IR_HI_HI;
    n.txd_pin = ir_en ? ir_pulse : (s.tx_busy ? s.tx_shift[0] : 1'b1);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (s.awready && awvalid) begin
      n.aw_got  = 1'b1;
      n.aw_addr = awaddr;
    end
    if (s.wready && wvalid) begin
      n.w_got  = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      wr       = s.w_strb[0];
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = uart_irda_pkg::RESP_OK;
      unique case (s.aw_addr)
        uart_irda_pkg::ADDR_DATA: begin
          if (wr) begin
            n.tx_hold          = s.w_data[7:0];
            n.tx_holding_empty = 1'b0;
          end
        end
        uart_irda_pkg::ADDR_CTL0: if (wr) n.ctl0 = s.w_data[3:0];
        uart_irda_pkg::ADDR_CTL1: if (wr) n.ctl1 = s.w_data[5:0];
        uart_irda_pkg::ADDR_NODE: if (wr) n.node = s.w_data[7:0];
        uart_irda_pkg::ADDR_BAUD: begin
          if (wr) n.baud_div[7:0] = s.w_data[7:0];
          if (s.w_strb[1]) n.baud_div[15:8] = s.w_data[15:8];
        end
        uart_irda_pkg::ADDR_STAT: ;
        default: n.bresp = uart_irda_pkg::RESP_ERR;
      endcase
    end
    n.awready = ~n.aw_got & ~n.bvalid;
    n.wready  = ~n.w_got & ~n.bvalid;
    n.arready = ~n.rvalid;

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    // Multidrop gating by scheme and last address.
    if (n.ctl1[uart_irda_pkg::C1_MDEN]) begin
      unique case (n.ctl1[uart_irda_pkg::C1_SCH +: 2])
        2'h0: irq_ok = 1'b1;
        2'h1: irq_ok = n.rx_is_addr;
        2'h2: irq_ok = ~n.rx_is_addr & n.addr_match;
        2'h3: irq_ok = n.addr_match;
      endcase
    end
    n.rx_irq = (n.rx_avail & n.ctl1[uart_irda_pkg::C1_DIE] & irq_ok) |
               n.ovr_pend | n.overrun | n.framing | n.parity_err |
               n.break_detected;

    next_s = n;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset to constants only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s                  <= '0;
      s.rx_s1            <= 1'b1;
      s.rx_s2            <= 1'b1;
      s.rx_prev          <= 1'b1;
      s.baud_div         <= uart_irda_pkg::BAUD_RST;
      s.rx_st            <= uart_irda_pkg::RX_IDLE;
      s.tx_holding_empty <= 1'b1;
      s.dec_out          <= 1'b1;
      s.txd_pin          <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule : uart_irda_rx

`default_nettype wire

// ==== uart_rx_irq_infrared_endec_test.sv ====
`default_nettype none

`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
  end \
end

// ----------------------------------------
// Self-checking bench for the serial block
// ----------------------------------------
module uart_rx_irq_infrared_endec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rxd_pin, txd_pin, rx_irq;
  logic [7:0]  awaddr, araddr;  // Register offsets.
  logic [31:0] wdata, rdata, v; // Bus data and the last word read.
  logic [1:0]  bresp, rresp, r; // Answers and the last read answer.
  logic [3:0]  wstrb;           // All byte lanes written.
  int          errors, tests_run;
  uart_irda_rx uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .rx_irq(rx_irq));
  uart_irda_peer peer (.aclk(aclk), .rxd_pin(rxd_pin));
  always #5 aclk = ~aclk;  // 100 MHz.
  // Bus write: each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask : wr
  // Bus read: the answer is kept in v and r.
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        {v, r} = {rdata, rresp};
      end
    end while (arvalid || rready);
  endtask : rd
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(v, e)
  endtask : chk_rd
  // Send a frame, then poll status until a byte is held.
  task automatic rx(input logic [8:0] d, input int n, input logic s, input logic ir, input int bt);
    peer.send(d, n, s, ir, bt);
    for (int i = 0; i < 20; i++) begin
      rd(8'h04);
      if (v[0]) break;
    end
  endtask : rx
  // Data interrupt at a divisor of three.
  task automatic t_rx();
    wr(8'h14, 32'h3);
    wr(8'h0c, 32'h8);
    wr(8'h08, 32'h1);
    rx(9'ha5, 8, 1'b1, 1'b0, 48);
    `CHK(rx_irq, 1'b1)
    chk_rd(8'h04, 32'h21);
    chk_rd(8'h00, 32'ha5);
    chk_rd(8'h04, 32'h20);
    `CHK(rx_irq, 1'b0)
    wr(8'h14, 32'h1);
  endtask : t_rx
  // Masked data, then an overrun behind the held byte.
  task automatic t_ovr();
    wr(8'h0c, 32'h0);
    rx(9'h11, 8, 1'b1, 1'b0, 16);
    `CHK(rx_irq, 1'b0)
    rx(9'h22, 8, 1'b1, 1'b0, 16);
    `CHK(rx_irq, 1'b1)
    chk_rd(8'h04, 32'h21);
    chk_rd(8'h00, 32'h11);
    chk_rd(8'h04, 32'h23);
    rd(8'h00);
    chk_rd(8'h04, 32'h20);
  endtask : t_ovr
  // A break dropped behind a held byte, then a break alone.
  task automatic t_brk();
    peer.send(9'h11, 8, 1'b1, 1'b0, 16);
    rx(9'h0, 8, 1'b0, 1'b0, 16);
    chk_rd(8'h00, 32'h11);
    rd(8'h04);
    `CHK({v[4], v[1], v[0]}, 3'h7)
    rd(8'h00);
    rx(9'h0, 8, 1'b0, 1'b0, 16);
    `CHK({rx_irq, v[4], v[2]}, 3'h7)
    rd(8'h00);
  endtask : t_brk
  // Every address scheme: a matching address, then a data byte.
  task automatic t_mp();
    wr(8'h10, 32'h5a);
    for (int s = 0; s < 4; s++) begin
      wr(8'h0c, 32'h9 | (s << 1));
      rx(9'h15a, 9, 1'b1, 1'b0, 16);
      if (s != 3) `CHK(rx_irq, s != 2)
      rd(8'h00);
      rx(9'h033, 9, 1'b1, 1'b0, 16);
      `CHK(rx_irq, s != 1)
      rd(8'h00);
    end
    wr(8'h0c, 32'h0);
  endtask : t_mp
  // Infrared transmit of two bytes; pulses on the pin are counted.
  task automatic t_irtx();
    int   n;
    logic p;
    n = 0;
    p = 1'b0;
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h10);
    wr(8'h08, 32'h2);
    fork
      begin
        wr(8'h00, 32'h55);
        wr(8'h00, 32'hff);
        rd(8'h04);
        `CHK(v[5], 1'b0)
      end
      repeat (400) begin
        @(posedge aclk);
        n += int'(txd_pin && !p);
        p = txd_pin;
      end
    join
    `CHK(n, 6)
    wr(8'h08, 32'h0);
  endtask : t_irtx
  // Infrared receive; the line is made idle low before the decoder wakes.
  task automatic t_irrx();
    peer.idle(1'b1);
    wr(8'h0c, 32'h10);
    wr(8'h08, 32'h1);
    rx(9'h5a, 8, 1'b1, 1'b1, 16);
    chk_rd(8'h00, 32'h5a);
    rx(9'h00, 8, 1'b1, 1'b1, 16);
    chk_rd(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    peer.idle(1'b0);
    wr(8'h0c, 32'h0);
  endtask : t_irrx
  task automatic give_verdict();
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // Reset, reset values, unmapped read, scenarios.
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_rd(8'h04, 32'h20);
    chk_rd(8'h14, 32'h1);
    rd(8'h40);
    `CHK({r, v}, {uart_irda_pkg::RESP_ERR, 32'h0})
    t_rx();
    t_ovr();
    t_brk();
    t_mp();
    t_irtx();
    t_irrx();
    give_verdict();
  end
  // Watchdog.
  initial begin
    repeat (30000) @(posedge aclk);
    errors++;
    give_verdict();
  end
endmodule : uart_rx_irq_infrared_endec_test

`default_nettype wire
